/* rtl/rtst_pkg.sv */
// Constants shared by the second-rate trim block and its window counter
package rtst_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// APB geometry
	localparam int unsigned APB_ADDR_W = 8;
	localparam int unsigned APB_DATA_W = 32;
	localparam int unsigned APB_STRB_W = 4;

	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_CONTROL_ONE   = 6'h0E;
	localparam logic [5:0] IDX_SECOND_TRIM   = 6'h10;
	localparam logic [5:0] IDX_TRIM_STATUS   = 6'h11;
	localparam logic [5:0] IDX_SECOND_LENGTH = 6'h12;
	localparam logic [5:0] IDX_SECOND_COUNT  = 6'h13;

	localparam logic [7:0] ADDR_CONTROL_ONE   = {IDX_CONTROL_ONE, 2'h0};
	localparam logic [7:0] ADDR_SECOND_TRIM   = {IDX_SECOND_TRIM, 2'h0};
	localparam logic [7:0] ADDR_TRIM_STATUS   = {IDX_TRIM_STATUS, 2'h0};
	localparam logic [7:0] ADDR_SECOND_LENGTH = {IDX_SECOND_LENGTH, 2'h0};
	localparam logic [7:0] ADDR_SECOND_COUNT  = {IDX_SECOND_COUNT, 2'h0};

	////////////////////////////////////////////////////////////////////////////////
	// Field layout and reset values
	localparam int unsigned TRIM_CODE_LSB    = 0;
	localparam int unsigned TRIM_CODE_W      = 7;
	localparam int unsigned INTERVAL_SEL_BIT = 7;
	localparam logic [7:0]  CONTROL_ONE_RST  = 8'h00;
	localparam logic [7:0]  SECOND_TRIM_RST  = 8'h00;

	// Control pattern that selects the 1 Hz pulse on the interrupt pin
	localparam logic [7:0]  PULSE_SEL_MASK   = 8'hCF;
	localparam logic [7:0]  PULSE_SEL_VALUE  = 8'h03;

	// Status register fields
	localparam int unsigned STAT_TRIM_ACTIVE = 0;
	localparam int unsigned STAT_PON         = 1;
	localparam int unsigned STAT_INT_PIN     = 2;
	localparam int unsigned STAT_CORR_SLOT   = 3;
	localparam int unsigned STAT_INTERVAL    = 4;
	localparam int unsigned STAT_SEC_POS_LSB = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Timebase
	localparam int unsigned LEN_W            = 17;
	localparam logic [16:0] OSC_PER_SECOND   = 17'h08000;
	localparam logic [16:0] OSC_HALF_SECOND  = 17'h04000;
	localparam logic [16:0] TRIM_STEP_CYCLES = 17'h00002;
	localparam int unsigned SEC_POS_W        = 6;
	localparam logic [5:0]  WINDOW_SHORT     = 6'h14;
	localparam logic [5:0]  WINDOW_LONG      = 6'h3C;

	// Code points of the signed trim code
	localparam logic [6:0]  CODE_GAIN_BASE   = 7'h01;
	localparam logic [7:0]  CODE_LOSS_BASE   = 8'h80;
	localparam logic [6:0]  CODE_LOSS_NULL   = 7'h41;

endpackage

/* rtl/rtst_top.sv */
// Second-rate trim of the timekeeping chain, with APB register access
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps

module rtst_top (
	// Clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           reset,
	// APB slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [rtst_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [rtst_pkg::APB_DATA_W-1:0] pwdata,
	input  wire logic [rtst_pkg::APB_STRB_W-1:0] pstrb,
	output logic      [rtst_pkg::APB_DATA_W-1:0] prdata,
	output logic                                pready,
	output logic                                pslverr,
	// Oscillator and power-on flag
	input  wire logic                           osc_in,
	input  wire logic                           power_on_flag,
	output logic                                osc_clock_out_pin,
	// Open-drain interrupt pin
	input  wire logic                           interrupt_out_pin_in,
	output logic                                interrupt_out_pin_out,
	output logic                                interrupt_out_pin_oe_n,
	// Seconds timebase
	output logic                                second_tick
);
	import rtst_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Pin synchronisers: bit 0 oscillator, bit 1 power-on flag, bit 2 interrupt pin
	logic [2:0]  pin_raw;
	logic [2:0]  pin_s1;
	logic [2:0]  pin_s2;
	logic [2:0]  pin_s3;
	logic [2:0]  pin_lvl;
	logic        osc_rise;
	logic        pon_set;

	// Software registers
	logic [7:0]  control_one;
	logic [7:0]  second_trim;
	logic [6:0]  trim_code;
	logic        trim_active;
	logic        pulse_mode;

	// Timebase
	logic [16:0] sub_cnt;
	logic [16:0] trimmed_len;
	logic [16:0] cur_len;
	logic [16:0] last_len;
	logic        sec_end;
	logic [31:0] second_count;

	// Trim decode
	logic        code_null;
	logic        code_gain;
	logic [16:0] trim_mag;
	logic [16:0] trim_delta;
	logic        pulse_low;

	// Bus decode
	logic        apb_setup;
	logic        apb_write;
	logic        addr_ok;
	logic        addr_writable;
	logic        wr_control_one;
	logic        wr_second_trim;
	logic [31:0] status_word;
	logic [31:0] next_prdata;

	rtst_trim_if trim_link ();

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	assign pin_raw = {interrupt_out_pin_in, power_on_flag, osc_in};

	// Three flops per pin; a level counts once the second and third agree
	// The third flop filters a single sampled glitch on a slow pin edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_s1  <= 3'h0;
			pin_s2  <= 3'h0;
			pin_s3  <= 3'h0;
			pin_lvl <= 3'h0;
		end else begin
			pin_s1  <= pin_raw;
			pin_s2  <= pin_s1;
			pin_s3  <= pin_s2;
			pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
		end
	end

	// One core cycle per accepted oscillator rising edge
	assign osc_rise = pin_s2[0] & pin_s3[0] & ~pin_lvl[0];

	// Power-on flag as seen by the block
	assign pon_set = pin_lvl[1];

	////////////////////////////////////////////////////////////////////////////////
	// Clock output pin

	// Free-running copy of the oscillator; trim never reaches it
	// It lags the pin by five core cycles: three synchroniser flops, the level flop and the output flop
	always_ff @(posedge core_clk) begin
		if (reset) begin
			osc_clock_out_pin <= 1'b0;
		end else begin
			osc_clock_out_pin <= pin_lvl[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	// Setup and write qualifiers; a write needs the low byte strobe
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite & pstrb[0];

	// Zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;

	// Unmapped addresses answer with an error in the access phase
	assign pslverr = psel & penable & ~addr_ok;

	// Write strobes: one per writable register
	assign wr_control_one = apb_write & addr_writable & (paddr == ADDR_CONTROL_ONE);
	assign wr_second_trim = apb_write & addr_writable & (paddr == ADDR_SECOND_TRIM);

	// Status word: flags in the low bits, window position above them
	always_comb begin
		status_word                              = 32'h00000000;
		status_word[STAT_TRIM_ACTIVE]            = trim_active;
		status_word[STAT_PON]                    = pon_set;
		status_word[STAT_INT_PIN]                = pin_lvl[2];
		status_word[STAT_CORR_SLOT]              = trim_link.corr_slot;
		status_word[STAT_INTERVAL]               = second_trim[INTERVAL_SEL_BIT];
		status_word[STAT_SEC_POS_LSB+:SEC_POS_W] = trim_link.sec_pos;
	end

	// Address map
	always_comb begin
		addr_ok       = 1'b0;
		addr_writable = 1'b0;
		next_prdata   = 32'h00000000;
		unique case (paddr)
			ADDR_CONTROL_ONE: begin
				addr_ok       = 1'b1;
				addr_writable = 1'b1;
				next_prdata   = {24'h000000, control_one};
			end
			ADDR_SECOND_TRIM: begin
				addr_ok       = 1'b1;
				addr_writable = 1'b1;
				next_prdata   = {24'h000000, second_trim};
			end
			ADDR_TRIM_STATUS: begin
				addr_ok     = 1'b1;
				next_prdata = status_word;
			end
			ADDR_SECOND_LENGTH: begin
				addr_ok     = 1'b1;
				next_prdata = {15'h0000, cur_len};
			end
			ADDR_SECOND_COUNT: begin
				addr_ok     = 1'b1;
				next_prdata = second_count;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// Read data is captured in the setup cycle and stands through the access
	// Writes load zero so a write never echoes stale register contents
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (apb_setup) begin
			prdata <= pwrite ? 32'h00000000 : next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers

	// Control register; the power-on flag clears it while set
	// A write in the same cycle as the flag is lost, the clear wins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			control_one <= CONTROL_ONE_RST;
		end else if (pon_set) begin
			control_one <= CONTROL_ONE_RST;
		end else if (wr_control_one) begin
			control_one <= pwdata[7:0];
		end
	end

	// Trim register: interval bit on top, seven-bit signed code below
	// Writes while the power-on flag is high are lost
	always_ff @(posedge core_clk) begin
		if (reset) begin
			second_trim <= SECOND_TRIM_RST;
		end else if (pon_set) begin
			second_trim <= SECOND_TRIM_RST;
		end else if (wr_second_trim) begin
			second_trim <= pwdata[7:0];
		end
	end

	assign trim_code = second_trim[TRIM_CODE_LSB+:TRIM_CODE_W];

	// Pulse selection by the documented control pattern
	assign pulse_mode = (control_one & PULSE_SEL_MASK) == PULSE_SEL_VALUE;

	////////////////////////////////////////////////////////////////////////////////
	// Trim decode

	// Code classes and magnitude; the four null codes never lengthen or shorten
	always_comb begin
		code_null = 1'b0;
		code_gain = 1'b0;
		trim_mag  = 17'h00000;
		if (trim_code == 7'h00) begin
			// All-zero code switches correction off, whatever the interval bit
			code_null = 1'b1;
		end else if (trim_code == CODE_GAIN_BASE) begin
			code_null = 1'b1;
		end else if (!trim_code[6]) begin
			// Gain: magnitude counted upward from 01h, second lengthened
			code_gain = 1'b1;
			trim_mag  = {10'h000, trim_code - CODE_GAIN_BASE};
		end else if (trim_code <= CODE_LOSS_NULL) begin
			// Most negative codes sit outside the usable range and do nothing
			code_null = 1'b1;
		end else begin
			// Loss: magnitude is the distance below 80h, second shortened
			trim_mag = {9'h000, CODE_LOSS_BASE - {1'b0, trim_code}};
		end
	end

	// Two oscillator cycles per unit; the ppm size follows from the window length
	assign trim_delta = 17'(trim_mag * TRIM_STEP_CYCLES);

	// Length in oscillator cycles of the corrected second
	always_comb begin
		if (code_null) begin
			trimmed_len = OSC_PER_SECOND;
		end else if (code_gain) begin
			trimmed_len = OSC_PER_SECOND + trim_delta;
		end else begin
			trimmed_len = OSC_PER_SECOND - trim_delta;
		end
	end
	assign trim_active = (trimmed_len != OSC_PER_SECOND);

	// Only the corrected slot of the window uses the trimmed length
	assign cur_len  = trim_link.corr_slot ? trimmed_len : OSC_PER_SECOND;
	assign last_len = cur_len - 17'h00001;

	////////////////////////////////////////////////////////////////////////////////
	// Seconds timebase

	// A shortened length below the running count ends the second at once,
	// so a trim written late in a second can never stretch it past the wrap
	assign sec_end = osc_rise && (sub_cnt >= last_len);

	// Oscillator cycles within the current second
	// It only moves on an accepted oscillator edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sub_cnt <= 17'h00000;
		end else if (osc_rise) begin
			if (sec_end) begin
				sub_cnt <= 17'h00000;
			end else begin
				sub_cnt <= sub_cnt + 17'h00001;
			end
		end
	end

	// One-cycle second pulse and a running second count
	// The count wraps silently after 2^32 seconds
	always_ff @(posedge core_clk) begin
		if (reset) begin
			second_tick  <= 1'b0;
			second_count <= 32'h00000000;
		end else begin
			second_tick <= sec_end;
			if (sec_end) begin
				second_count <= second_count + 32'h00000001;
			end
		end
	end

	// Window counter link
	// The window counter sees the end of every second, trimmed or not
	assign trim_link.sec_tick     = sec_end;
	assign trim_link.interval_sel = second_trim[INTERVAL_SEL_BIT];

	rtst_window_cnt rtst_window_cnt_i (
		.core_clk (core_clk),
		.reset    (reset),
		.win      (trim_link.window)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt pin

	// Open drain: output level is always low, the enable does the signalling
	// Pin readback is through the synchroniser, for the status register
	assign interrupt_out_pin_out = 1'b0;

	// Low half of the pulse: the first OSC_HALF_SECOND oscillator cycles of every second, whatever its length
	assign pulse_low = pulse_mode && (sub_cnt < OSC_HALF_SECOND);

	// Pulse mode pulls the pin low for the first OSC_HALF_SECOND oscillator cycles of every second
	always_ff @(posedge core_clk) begin
		if (reset) begin
			interrupt_out_pin_oe_n <= 1'b1;
		end else begin
			interrupt_out_pin_oe_n <= ~pulse_low;
		end
	end

endmodule

/* rtl/rtst_trim_if.sv */
// Signals between the trim core and its correction window counter
`timescale 1ns/100ps
interface rtst_trim_if;
	logic       sec_tick;
	logic       interval_sel;
	logic       corr_slot;
	logic [5:0] sec_pos;

	modport core (
		output sec_tick,
		output interval_sel,
		input  corr_slot,
		input  sec_pos
	);

	modport window (
		input  sec_tick,
		input  interval_sel,
		output corr_slot,
		output sec_pos
	);
endinterface

/* rtl/rtst_window_cnt.sv */
// Correction window counter: marks the one corrected second in each window
`timescale 1ns/100ps
module rtst_window_cnt (
	// Clock and reset
	input wire logic     core_clk,
	input wire logic     reset,
	// Link to the trim core
	rtst_trim_if.window  win
);
	import rtst_pkg::*;

	logic [5:0] pos;
	logic [5:0] last_pos;

	////////////////////////////////////////////////////////////////////////////////
	// Window length follows the interval select bit
	assign last_pos = win.interval_sel ? (WINDOW_LONG - 6'h01)
	                                   : (WINDOW_SHORT - 6'h01);

	// Second position inside the window; a shorter window wraps at once
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pos <= 6'h00;
		end else if (win.sec_tick) begin
			if (pos >= last_pos) begin
				pos <= 6'h00;
			end else begin
				pos <= pos + 6'h01;
			end
		end
	end

	// Last second of the window is the corrected one
	assign win.corr_slot = (pos == last_pos);
	assign win.sec_pos   = pos;
endmodule

/* tb/rtst_top_props.sv */
// Concurrent checks on the ports of the second-rate trim top
`timescale 1ns/100ps
module rtst_top_props (
	// Clock and reset
	input wire logic                              core_clk,
	input wire logic                              reset,
	// APB
	input wire logic                              psel,
	input wire logic                              penable,
	input wire logic                              pwrite,
	input wire logic [rtst_pkg::APB_ADDR_W-1:0]   paddr,
	input wire logic [rtst_pkg::APB_DATA_W-1:0]   prdata,
	input wire logic                              pready,
	input wire logic                              pslverr,
	// Pins
	input wire logic                              osc_in,
	input wire logic                              osc_clock_out_pin,
	input wire logic                              interrupt_out_pin_out,
	input wire logic                              second_tick
);
	import rtst_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	// Bus phases
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	property p_ready; pready; endproperty
	property p_err_cause; pslverr |-> psel && penable; endproperty
	property p_err_unmap; s_setup ##0 paddr == 8'hFC ##1 s_access |-> pslverr; endproperty
	property p_map_ok; s_setup ##0 paddr == ADDR_SECOND_TRIM ##1 s_access |-> !pslverr; endproperty
	property p_err_data; pslverr |-> prdata == '0; endproperty
	property p_wr_data; s_setup ##0 pwrite ##1 s_access |-> prdata == '0; endproperty
	// Untrimmed clock follows the oscillator; second pulse is one cycle wide
	property p_osc_rise; $rose(osc_in) |-> ##[1:6] osc_clock_out_pin; endproperty
	property p_osc_fall; $fell(osc_in) |-> ##[1:6] !osc_clock_out_pin; endproperty
	property p_tick; second_tick |=> !second_tick; endproperty
	property p_od; interrupt_out_pin_out == 1'b0; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	a_err_cause: assert property (p_err_cause) else $error("pslverr outside access");
	a_err_unmap: assert property (p_err_unmap) else $error("no error on unmapped address");
	a_map_ok: assert property (p_map_ok) else $error("error on mapped address");
	a_err_data: assert property (p_err_data) else $error("read data on error");
	a_wr_data: assert property (p_wr_data) else $error("read data on write");
	a_osc_rise: assert property (p_osc_rise) else $error("clock out late high");
	a_osc_fall: assert property (p_osc_fall) else $error("clock out late low");
	a_tick: assert property (p_tick) else $error("second pulse too long");
	a_od: assert property (p_od) else $error("open drain drives high");
endmodule
bind rtst_top rtst_top_props rtst_top_props_i (.core_clk, .reset, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .osc_in, .osc_clock_out_pin, .interrupt_out_pin_out,
	.second_tick);

/* tb/rtst_top_tb.sv */
// Self-checking bench for the second-rate trim top
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module rtst_top_tb;
	import rtst_pkg::*;
	logic        core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic        osc_in = 0, power_on_flag = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [3:0]  pstrb = 0;
	logic [31:0] prdata;
	logic        pready, pslverr, osc_out, int_out, oe_n, tick;
	int          n_mismatch = 0, checks_done = 0, osc_cnt = 0;
	logic [32:0] exp_q[$];
	rtst_top rtst_top_i (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_in(osc_in), .power_on_flag(power_on_flag),
		.osc_clock_out_pin(osc_out), .interrupt_out_pin_in(oe_n ? 1'b1 : int_out),
		.interrupt_out_pin_out(int_out), .interrupt_out_pin_oe_n(oe_n), .second_tick(tick));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and a fast oscillator, four core cycles per level
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		osc_cnt <= (osc_cnt + 1) % 4;
		if (osc_cnt == 3) osc_in <= ~osc_in;
	end
	// Completed transfers are compared with the oldest noted expectation
	always @(posedge core_clk) begin
		logic [32:0] exp_v;
		if (!reset && psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			`CHK({pslverr, prdata}, exp_v);
		end
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One APB transfer held until pready is seen high
	// The run is shorter than one second, so no corrected second meets bus traffic
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [32:0] x);
		int n;
		@(posedge core_clk);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d}; pstrb <= s;
		exp_q.push_back(x);
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin n_mismatch++; finish_test(); end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d, 4'h1, 33'h000000000);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 8'h00, 4'hF, {1'b0, x});
	endtask
	// Bounded wait for the pulse pin level
	task automatic wait_oe(input logic v);
		int n;
		n = 0;
		while (oe_n !== v && n < 400) begin @(posedge core_clk); n++; end
		`CHK(oe_n, v);
		if (n >= 400) finish_test();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] codes[9];
		logic [31:0] r;
		void'($urandom(32'h81C4));
		r = $urandom;
		codes = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h09, 8'h46, 8'h99, 8'h80, 8'h00};
		codes[8] = {r[7], (r[6:1] == 6'h20) ? 7'h42 : r[6:0]};
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		rd(ADDR_CONTROL_ONE, 32'h00000000);
		rd(ADDR_SECOND_TRIM, 32'h00000000);
		foreach (codes[i]) begin
			wr(ADDR_SECOND_TRIM, codes[i]);
			rd(ADDR_SECOND_TRIM, {24'h000000, codes[i]});
			rd(ADDR_SECOND_LENGTH, 32'h00008000);
			rd(ADDR_TRIM_STATUS, {27'h0000000, codes[i][7], 3'h2,
				!(codes[i][6:0] inside {7'h00, 7'h01, 7'h40, 7'h41})});
		end
		rd(ADDR_SECOND_COUNT, 32'h00000000);
		xfer(1'b1, ADDR_SECOND_TRIM, 8'h2A, 4'hE, 33'h000000000);
		rd(ADDR_SECOND_TRIM, {24'h000000, codes[8]});
		wr(ADDR_SECOND_LENGTH, 8'h12);
		rd(ADDR_SECOND_LENGTH, 32'h00008000);
		xfer(1'b0, 8'hFC, 8'h00, 4'hF, {1'b1, 32'h00000000});
		xfer(1'b1, 8'hFC, 8'h5A, 4'h1, {1'b1, 32'h00000000});
		wr(ADDR_CONTROL_ONE, 8'h03);
		wait_oe(1'b0);
		wr(ADDR_CONTROL_ONE, 8'h07);
		wait_oe(1'b1);
		wr(ADDR_CONTROL_ONE, 8'h33);
		wait_oe(1'b0);
		rd(ADDR_CONTROL_ONE, 32'h00000033);
		power_on_flag <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(ADDR_SECOND_TRIM, 32'h00000000);
		wr(ADDR_SECOND_TRIM, 8'h09);
		rd(ADDR_SECOND_TRIM, 32'h00000000);
		rd(ADDR_CONTROL_ONE, 32'h00000000);
		wait_oe(1'b1);
		rd(ADDR_TRIM_STATUS, 32'h00000006);
		power_on_flag <= 1'b0;
		repeat (8) @(posedge core_clk);
		wr(ADDR_SECOND_TRIM, 8'h46);
		rd(ADDR_SECOND_TRIM, 32'h00000046);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rd(ADDR_SECOND_TRIM, 32'h00000000);
		finish_test();
	end
endmodule
